// ==== src/bdfp_cfg.svh ====
// Purpose: constants of the bias driver fault protection block
// Assumes: 20 MHz mclk, APB register access
// Notes: times are kept in their own unit, cycle counts derive from them
`ifndef BDFP_CFG_SVH
`define BDFP_CFG_SVH
// clock
`define BDFP_CLK_HZ 20000000
`define BDFP_NS_PER_S 1000000000
`define BDFP_CYC(ns) ((((ns) * (`BDFP_CLK_HZ / 1000000)) + 999) / 1000)
// qualifier and blanking times in ns
`define BDFP_QUAL_NS 100
`define BDFP_OV_BLANK_NS 1300
`define BDFP_SETTLE_NS 100000
`define BDFP_QUAL_CYC `BDFP_CYC(`BDFP_QUAL_NS)
`define BDFP_OV_BLANK_CYC `BDFP_CYC(`BDFP_OV_BLANK_NS)
`define BDFP_SETTLE_CYC `BDFP_CYC(`BDFP_SETTLE_NS)
// long times in us
`define BDFP_SS_US 1500
`define BDFP_RESTART_US 100000
`define BDFP_SLOW_UP_US 2100
`define BDFP_SLOW_DN_US 180000
`define BDFP_US_CYC(us) ((us) * (`BDFP_CLK_HZ / 1000000))
// slow timer up step, down step derives from the two times
`define BDFP_SLOW_UP_STEP 600
// current limits in mA
`define BDFP_TOP_LIMIT_MA 1000
`define BDFP_FAST_MAX_MA 5000
`define BDFP_FAST_MULT 5
`define BDFP_LEVELS 6
// limit pin delta voltage decode bounds in mV (50 uA times Rth)
`define BDFP_DV_L1_MV 12'd985
`define BDFP_DV_L2_MV 12'd712
`define BDFP_DV_L3_MV 12'd500
`define BDFP_DV_L4_MV 12'd325
`define BDFP_DV_L5_MV 12'd185
// register offsets
`define BDFP_OFF_CTRL 12'h000
`define BDFP_OFF_STATUS 12'h004
`define BDFP_OFF_SLOW 12'h008
`define BDFP_OFF_MEAS 12'h00C
`define BDFP_CTRL_RESET 1'b1
// fault cause bits
`define BDFP_CAUSE_SLOW 0
`define BDFP_CAUSE_FAST 1
`define BDFP_CAUSE_OV 2
`define BDFP_CAUSE_TSD 3
`endif

// ==== src/bdfp_pkg.sv ====
// Purpose: types of the bias driver fault protection block
// Assumes: constants come from bdfp_cfg.svh
// Notes: whole module state is one packed struct
`include "bdfp_cfg.svh"
package bdfp_pkg;
  typedef enum logic [2:0] {
    ST_MREG = 3'h0,
    ST_MON = 3'h1,
    ST_MOFF = 3'h2,
    ST_SOFT = 3'h3,
    ST_RUN = 3'h4,
    ST_FAULT = 3'h5
  } bdfp_state_t;

  typedef struct packed {
    bdfp_state_t state;
    logic [10:0] s1;
    logic [10:0] s2;
    logic ls_on_d;
    logic [31:0] tmr;
    logic [31:0] slow_cnt;
    logic [4:0] slow_q;
    logic [4:0] fast_q;
    logic [5:0] ov_q;
    logic cyc_over;
    logic prev_over;
    logic [11:0] meas_on;
    logic [11:0] meas_off;
    logic [2:0] level;
    logic [3:0] cause;
    logic allow;
    logic src_en;
    logic pin_oe;
    logic sw_en;
    logic fault;
    logic [10:0] slow_ma;
    logic [12:0] fast_ma;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } bdfp_regs_t;
endpackage

// ==== src/bdfp_top.sv ====
// Purpose: fault supervisor for an isolated-bias half-bridge transformer driver
// Assumes: analog comparators and limit pin converter sit outside, APB host
// Notes: pin comparator levels pass two flops; adc_mv is on mclk already
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`include "bdfp_cfg.svh"

// Summary of operation
// - slow trip when low-side current overruns limit every cycle for 2.1 ms
// - slow detector sees low-side current only while flowing into switch node
// - fast trip when either switch exceeds five times limit for 100 ns
// - slow protection disabled during soft-start
// - fast threshold fixed at 5 A during soft-start
// - after soft-start slow limit is programmed value, fast is five times it
// - slow timer counts up in cycles over limit longer than 100 ns
// - slow timer counts down in cycles never over limit longer than 100 ns
// - up from zero to trip takes 2.1 ms, down to zero takes 180 ms
// - fast path rejects overcurrent pulses shorter than 100 ns
// - wait 100 ms restart delay after overcurrent trip
// - after regulator settles, toggle 50 uA source and sample pin each state
// - limit from sample difference, then leave source off for dead-time use
// - six limit levels, largest resistance lowest, smallest gives full limit
// - highest slow limit equals 1 A
// - overvoltage trips only after 1.3 us above fixed level
// - overvoltage enters fault mode, stops switching, pulls fault pin low
// - overvoltage restart after 100 ms and only below release level
// - thermal shutdown enters fault mode, stops switching, pulls pin low
// - thermal fault holds until temperature below release hysteresis
// - 1.5 ms soft-start at start-up and every fault recovery
// - fault pin low from either side inhibits all switching
module bdfp_top #(
  parameter int unsigned SS_CYC = `BDFP_US_CYC(`BDFP_SS_US),
  parameter int unsigned RESTART_CYC = `BDFP_US_CYC(`BDFP_RESTART_US),
  parameter int unsigned SLOW_UP_CYC = `BDFP_US_CYC(`BDFP_SLOW_UP_US),
  parameter int unsigned SLOW_DN_CYC = `BDFP_US_CYC(`BDFP_SLOW_DN_US)
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic regulator_ok,
  input wire logic ls_on,
  input wire logic into_switch_node,
  input wire logic ls_over_limit,
  input wire logic hs_over_fast,
  input wire logic ls_over_fast,
  input wire logic ov_above_trip,
  input wire logic ov_below_release,
  input wire logic thermal_shutdown,
  input wire logic thermal_cool,
  input wire logic fault_pin_in,
  input wire logic [11:0] adc_mv,
  output logic fault_pin_out,
  output logic fault_pin_oe,
  output logic cur_src_en,
  output logic switching_enable,
  output logic fault_mode,
  output logic [10:0] programmed_current_limit,
  output logic [12:0] fast_limit_ma
);
  localparam logic [31:0] QUAL = 32'(`BDFP_QUAL_CYC);
  localparam logic [31:0] OV_BLANK = 32'(`BDFP_OV_BLANK_CYC);
  localparam logic [31:0] SETTLE = 32'(`BDFP_SETTLE_CYC);
  localparam logic [31:0] UP_STEP = 32'(`BDFP_SLOW_UP_STEP);
  localparam logic [31:0] SLOW_TRIP = 32'(SLOW_UP_CYC * `BDFP_SLOW_UP_STEP);
  localparam logic [31:0] DN_STEP = 32'(SLOW_UP_CYC * `BDFP_SLOW_UP_STEP / SLOW_DN_CYC);

  bdfp_pkg::bdfp_regs_t r;
  bdfp_pkg::bdfp_regs_t n;

  logic reg_ok_s, ls_on_s, into_s, ls_ovl_s, hs_fast_s, ls_fast_s;
  logic ov_s, ov_rel_s, tsd_s, cool_s, pin_s;
  logic slow_cond, fast_cond, slow_trip, fast_trip, ov_trip, running, access;
  logic [11:0] dv;

  // synchronised comparator and pin levels, second stage only
  assign {reg_ok_s, ls_on_s, into_s, ls_ovl_s, hs_fast_s, ls_fast_s,
          ov_s, ov_rel_s, tsd_s, cool_s, pin_s} = r.s2;
  assign running = (r.state == bdfp_pkg::ST_SOFT) || (r.state == bdfp_pkg::ST_RUN);
  // slow detector: low side, current into node, normal running only
  assign slow_cond = ls_on_s && into_s && ls_ovl_s && (r.state == bdfp_pkg::ST_RUN);
  assign fast_cond = (hs_fast_s || ls_fast_s) && running;
  // fast trip needs the level held for the whole qualifier
  assign fast_trip = fast_cond && ({27'h0, r.fast_q} == QUAL - 32'h1);
  assign slow_trip = (r.state == bdfp_pkg::ST_RUN) && r.prev_over &&
                     (r.slow_cnt + UP_STEP >= SLOW_TRIP);
  assign ov_trip = ov_s && running && ({26'h0, r.ov_q} == OV_BLANK - 32'h1);
  assign access = psel && penable && !r.pready;
  assign dv = (r.meas_on > adc_mv) ? r.meas_on - adc_mv : 12'h000;

  // next state of the whole block
  always_comb begin
    n = r;
    n.s1 = {regulator_ok, ls_on, into_switch_node, ls_over_limit, hs_over_fast,
            ls_over_fast, ov_above_trip, ov_below_release, thermal_shutdown,
            thermal_cool, fault_pin_in};
    n.s2 = r.s1;
    n.ls_on_d = ls_on_s;
    // qualifier counters, saturating
    n.fast_q = fast_cond ? ((r.fast_q == 5'h1F) ? r.fast_q : r.fast_q + 5'h01) : 5'h00;
    n.slow_q = slow_cond ? ((r.slow_q == 5'h1F) ? r.slow_q : r.slow_q + 5'h01) : 5'h00;
    n.ov_q = (ov_s && running) ? ((r.ov_q == 6'h3F) ? r.ov_q : r.ov_q + 6'h01) : 6'h00;
    // per switching cycle verdict, closed at each low-side turn-on
    if (slow_cond && ({27'h0, r.slow_q} >= QUAL)) begin
      n.cyc_over = 1'b1;
    end
    if (ls_on_s && !r.ls_on_d) begin
      n.prev_over = n.cyc_over;
      n.cyc_over = 1'b0;
    end
    // up-down slow timer, frozen outside normal running
    if (r.state == bdfp_pkg::ST_RUN) begin
      if (r.prev_over) begin
        n.slow_cnt = r.slow_cnt + UP_STEP;
      end else begin
        n.slow_cnt = (r.slow_cnt > DN_STEP) ? r.slow_cnt - DN_STEP : 32'h0;
      end
    end
    if (r.tmr != 32'h0) begin
      n.tmr = r.tmr - 32'h1;
    end
    // sequencer
    case (r.state)
      bdfp_pkg::ST_MREG: begin
        if (reg_ok_s) begin
          n.state = bdfp_pkg::ST_MON;
          n.tmr = SETTLE;
        end
      end
      bdfp_pkg::ST_MON: begin
        if (r.tmr == 32'h0) begin
          n.meas_on = adc_mv;
          n.state = bdfp_pkg::ST_MOFF;
          n.tmr = SETTLE;
        end
      end
      bdfp_pkg::ST_MOFF: begin
        if (r.tmr == 32'h0) begin
          n.meas_off = adc_mv;
          // larger delta means larger divider resistance, lower limit
          if (dv >= `BDFP_DV_L1_MV) begin
            n.level = 3'h1;
          end else if (dv >= `BDFP_DV_L2_MV) begin
            n.level = 3'h2;
          end else if (dv >= `BDFP_DV_L3_MV) begin
            n.level = 3'h3;
          end else if (dv >= `BDFP_DV_L4_MV) begin
            n.level = 3'h4;
          end else if (dv >= `BDFP_DV_L5_MV) begin
            n.level = 3'h5;
          end else begin
            n.level = 3'h6;
          end
          n.state = bdfp_pkg::ST_SOFT;
          n.tmr = 32'(SS_CYC);
        end
      end
      bdfp_pkg::ST_SOFT: begin
        if (r.tmr == 32'h0) begin
          n.state = bdfp_pkg::ST_RUN;
        end
      end
      bdfp_pkg::ST_RUN: begin
      end
      bdfp_pkg::ST_FAULT: begin
        // delay and release conditions must all hold
        if ((r.tmr == 32'h0) && (!r.cause[`BDFP_CAUSE_OV] || ov_rel_s) &&
            (!r.cause[`BDFP_CAUSE_TSD] || cool_s)) begin
          n.state = bdfp_pkg::ST_SOFT;
          n.tmr = 32'(SS_CYC);
        end
      end
      default: begin
        n.state = bdfp_pkg::ST_MREG;
      end
    endcase
    // any trip enters the common fault mode
    if (running && (slow_trip || fast_trip || ov_trip || tsd_s)) begin
      n.state = bdfp_pkg::ST_FAULT;
      n.tmr = 32'(RESTART_CYC);
      n.slow_cnt = 32'h0;
      n.cyc_over = 1'b0;
      n.prev_over = 1'b0;
      n.cause = {tsd_s, ov_trip, fast_trip, slow_trip};
    end
    // pin side outputs follow the next state
    n.src_en = (n.state == bdfp_pkg::ST_MON);
    n.pin_oe = (n.state == bdfp_pkg::ST_MREG) || (n.state == bdfp_pkg::ST_FAULT);
    n.fault = (n.state == bdfp_pkg::ST_FAULT);
    n.sw_en = ((n.state == bdfp_pkg::ST_SOFT) || (n.state == bdfp_pkg::ST_RUN)) &&
              pin_s && r.allow;
    n.slow_ma = 11'((32'(n.level) * `BDFP_TOP_LIMIT_MA * 2 + `BDFP_LEVELS) /
                    (2 * `BDFP_LEVELS));
    if (n.state == bdfp_pkg::ST_RUN) begin
      n.fast_ma = 13'(32'(n.slow_ma) * `BDFP_FAST_MULT);
    end else begin
      n.fast_ma = 13'(`BDFP_FAST_MAX_MA);
    end
    // a write lands at the completing edge, while pready is seen high
    if (psel && penable && r.pready && pwrite && (paddr == `BDFP_OFF_CTRL)) begin
      n.allow = pwdata[0];
    end
    // apb slave, answers in the second access cycle
    n.pready = access;
    n.pslverr = 1'b0;
    n.prdata = 32'h0;
    if (access) begin
      case (paddr)
        `BDFP_OFF_CTRL: begin
          n.prdata = {31'h0, r.allow};
        end
        `BDFP_OFF_STATUS: begin
          n.prdata = {21'h0, r.sw_en, r.cause, r.level, r.state};
        end
        `BDFP_OFF_SLOW: begin
          n.prdata = r.slow_cnt;
        end
        `BDFP_OFF_MEAS: begin
          n.prdata = {4'h0, r.meas_off, 4'h0, r.meas_on};
        end
        default: begin
          n.pslverr = 1'b1;
        end
      endcase
      if (pwrite) begin
        n.prdata = 32'h0;
      end
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (reset) begin
      r <= '0;
      r.state <= bdfp_pkg::ST_MREG;
      r.allow <= `BDFP_CTRL_RESET;
      r.pin_oe <= 1'b1;
      r.fast_ma <= 13'(`BDFP_FAST_MAX_MA);
    end else begin
      r <= n;
    end
  end

  // outputs straight from the state register, except fault_pin_out which is tied low
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign fault_pin_out = 1'b0;
  assign fault_pin_oe = r.pin_oe;
  assign cur_src_en = r.src_en;
  assign switching_enable = r.sw_en;
  assign fault_mode = r.fault;
  assign programmed_current_limit = r.slow_ma;
  assign fast_limit_ma = r.fast_ma;

  // checks beside the logic they guard
  a_soft_slow_frozen: assert property (@(posedge mclk) disable iff (reset)
    (r.state == bdfp_pkg::ST_SOFT) && ($past(r.state) == bdfp_pkg::ST_SOFT)
    |-> $stable(r.slow_cnt))
    else $error("slow timer moved during soft-start");
  a_soft_fast_max: assert property (@(posedge mclk) disable iff (reset)
    (r.state == bdfp_pkg::ST_SOFT) |-> (r.fast_ma == 13'(`BDFP_FAST_MAX_MA)))
    else $error("fast threshold not at maximum in soft-start");
  a_run_fast_five: assert property (@(posedge mclk) disable iff (reset)
    (r.state == bdfp_pkg::ST_RUN) |-> (32'(r.fast_ma) == 32'(r.slow_ma) * 5))
    else $error("fast threshold not five times limit");
  a_fast_pulse_held: assert property (@(posedge mclk) disable iff (reset)
    $rose(r.cause[`BDFP_CAUSE_FAST]) |-> $past(fast_cond, 1) && $past(fast_cond, 2))
    else $error("fast trip on short pulse");
  a_ov_blank_held: assert property (@(posedge mclk) disable iff (reset)
    $rose(r.cause[`BDFP_CAUSE_OV]) |-> $past(ov_s, 1) && $past(ov_s, 26))
    else $error("overvoltage trip before blanking time");
  a_fault_pin_low: assert property (@(posedge mclk) disable iff (reset)
    (r.state == bdfp_pkg::ST_FAULT) |-> r.pin_oe && !r.sw_en)
    else $error("fault mode without pin pull-down");
  a_pin_inhibit: assert property (@(posedge mclk) disable iff (reset)
    !pin_s |=> !switching_enable)
    else $error("switching while fault pin low");
  a_src_off_after: assert property (@(posedge mclk) disable iff (reset)
    (r.state inside {bdfp_pkg::ST_SOFT, bdfp_pkg::ST_RUN, bdfp_pkg::ST_FAULT})
    |-> !cur_src_en)
    else $error("limit pin source left on");
  a_restart_wait: assert property (@(posedge mclk) disable iff (reset)
    (r.state == bdfp_pkg::ST_FAULT) && (r.tmr != 32'h0) |=> (r.state == bdfp_pkg::ST_FAULT))
    else $error("restart before delay expired");
  a_slow_trip_level: assert property (@(posedge mclk) disable iff (reset)
    $rose(r.cause[`BDFP_CAUSE_SLOW]) |-> ($past(r.slow_cnt) + UP_STEP >= SLOW_TRIP))
    else $error("slow trip below threshold");
  a_thermal_hold: assert property (@(posedge mclk) disable iff (reset)
    (r.state == bdfp_pkg::ST_FAULT) && r.cause[`BDFP_CAUSE_TSD] && !cool_s
    |=> (r.state == bdfp_pkg::ST_FAULT))
    else $error("thermal restart while hot");

  // trip entry, release and timer direction checks
  a_fast_trip_enter: assert property (@(posedge mclk) disable iff (reset)
    fast_cond && $past(fast_cond)
    |=> (r.state == bdfp_pkg::ST_FAULT))
    else $error("fast overcurrent held without trip");
  a_ov_trip_enter: assert property (@(posedge mclk) disable iff (reset)
    ov_trip
    |=> (r.state == bdfp_pkg::ST_FAULT) && r.cause[`BDFP_CAUSE_OV] && r.pin_oe)
    else $error("overvoltage trip without fault mode");
  a_tsd_enter: assert property (@(posedge mclk) disable iff (reset)
    running && tsd_s
    |=> (r.state == bdfp_pkg::ST_FAULT) && r.cause[`BDFP_CAUSE_TSD])
    else $error("thermal shutdown without fault mode");
  a_ov_hold: assert property (@(posedge mclk) disable iff (reset)
    (r.state == bdfp_pkg::ST_FAULT) && r.cause[`BDFP_CAUSE_OV] && !ov_rel_s
    |=> (r.state == bdfp_pkg::ST_FAULT))
    else $error("overvoltage restart above release level");
  a_restart_soft: assert property (@(posedge mclk) disable iff (reset)
    (r.state == bdfp_pkg::ST_FAULT) ##1 (r.state != bdfp_pkg::ST_FAULT)
    |-> (r.state == bdfp_pkg::ST_SOFT) && (r.tmr == 32'(SS_CYC)))
    else $error("fault recovery without soft-start");
  a_soft_full: assert property (@(posedge mclk) disable iff (reset)
    (r.state == bdfp_pkg::ST_SOFT) && (r.tmr != 32'h0)
    |=> (r.state != bdfp_pkg::ST_RUN))
    else $error("soft-start cut short");
  a_limit_ceiling: assert property (@(posedge mclk) disable iff (reset)
    (r.state == bdfp_pkg::ST_RUN)
    |-> (r.slow_ma <= 11'(`BDFP_TOP_LIMIT_MA)))
    else $error("slow limit above top limit");
  a_level_range: assert property (@(posedge mclk) disable iff (reset)
    (r.state inside {bdfp_pkg::ST_SOFT, bdfp_pkg::ST_RUN, bdfp_pkg::ST_FAULT})
    |-> (r.level != 3'h0) && (r.level <= 3'h6))
    else $error("decoded level out of range");
  a_soft_no_slow: assert property (@(posedge mclk) disable iff (reset)
    (r.state == bdfp_pkg::ST_SOFT)
    |=> !$rose(r.cause[`BDFP_CAUSE_SLOW]))
    else $error("slow trip during soft-start");
  a_slow_down: assert property (@(posedge mclk) disable iff (reset)
    (r.state == bdfp_pkg::ST_RUN) && !r.prev_over
    |=> (r.slow_cnt <= $past(r.slow_cnt)))
    else $error("slow timer rose without over cycle");
  a_slow_up: assert property (@(posedge mclk) disable iff (reset)
    (r.state == bdfp_pkg::ST_RUN) && r.prev_over
    |=> (r.slow_cnt == $past(r.slow_cnt) + UP_STEP) || (r.state == bdfp_pkg::ST_FAULT))
    else $error("slow timer missed an up step");
  a_src_on_sample: assert property (@(posedge mclk) disable iff (reset)
    (r.state == bdfp_pkg::ST_MON) && (r.tmr == 32'h0)
    |-> cur_src_en)
    else $error("source off at on-state sample");
endmodule

// ==== verif/bdfp_stage_model.sv ====
// Purpose: power stage, comparator and limit pin model for the supervisor
// Assumes: one switching cycle every PER clocks while switching is enabled
// Notes: fault pin has a pull-up, a released pin reads high
module bdfp_stage_model #(
  parameter int unsigned PER = 20
) (
  input wire logic mclk,
  input wire logic switching_enable,
  input wire logic cur_src_en,
  input wire logic fault_pin_out,
  input wire logic fault_pin_oe,
  input wire logic ext_low,
  input wire logic overload,
  input wire logic [11:0] base_mv,
  input wire logic [11:0] dv_mv,
  output logic ls_on,
  output logic ls_over_limit,
  output logic fault_pin_in,
  output logic [11:0] adc_mv
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned ph = 0;
  // switching phase, the stage idles with the low side off
  always @(posedge mclk) begin
    if (switching_enable === 1'b1) ph <= (ph + 1) % PER;
    else ph <= 0;
  end
  // low side conducts in the second half of each cycle
  assign ls_on = (switching_enable === 1'b1) && (ph >= PER / 2);
  assign ls_over_limit = ls_on & overload;
  // divider voltage plus the source drop while the source is on
  assign adc_mv = (cur_src_en === 1'b1) ? 12'(base_mv + dv_mv) : base_mv;
  // open-drain wire, either side may pull it low
  assign fault_pin_in = !(fault_pin_oe && !fault_pin_out) && !ext_low;
endmodule

// ==== verif/tb.sv ====
// Purpose: self-checking bench for the bias driver fault supervisor
// Assumes: shortened soft-start, restart and slow timer counts
// Notes: expected read results wait in a queue until pready shows them
`include "bdfp_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned SS = 50;
  localparam int unsigned RS = 100;
  localparam int unsigned UP = 42;
  localparam logic [11:0] DVS [6] = '{12'h46F, 12'h343, 12'h253, 12'h195, 12'hFA, 12'h7D};
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0, adc_mv, base_mv = 0, dv_mv = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, ls_on, ls_over_limit, fault_pin_in, fault_pin_out, fault_pin_oe;
  logic cur_src_en, switching_enable, fault_mode, regulator_ok = 0, into_switch_node = 1;
  logic hs_over_fast = 0, ls_over_fast = 0, ov_above_trip = 0, ov_below_release = 1;
  logic thermal_shutdown = 0, thermal_cool = 1, ext_low = 0, overload = 0;
  logic [10:0] programmed_current_limit;
  logic [12:0] fast_limit_ma;
  logic [32:0] exp_q [$];
  int n_mismatch = 0, checks = 0, cyc = 0, n = 0;
  int seed = 32'ha1b2;

  bdfp_top #(.SS_CYC(SS), .RESTART_CYC(RS), .SLOW_UP_CYC(UP), .SLOW_DN_CYC(3600)) dut_u (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .regulator_ok(regulator_ok), .ls_on(ls_on), .into_switch_node(into_switch_node),
    .ls_over_limit(ls_over_limit), .hs_over_fast(hs_over_fast), .ls_over_fast(ls_over_fast),
    .ov_above_trip(ov_above_trip), .ov_below_release(ov_below_release),
    .thermal_shutdown(thermal_shutdown), .thermal_cool(thermal_cool),
    .fault_pin_in(fault_pin_in), .adc_mv(adc_mv), .fault_pin_out(fault_pin_out),
    .fault_pin_oe(fault_pin_oe), .cur_src_en(cur_src_en), .switching_enable(switching_enable),
    .fault_mode(fault_mode), .programmed_current_limit(programmed_current_limit),
    .fast_limit_ma(fast_limit_ma));
  bdfp_stage_model #(.PER(20)) model_u (
    .mclk(mclk), .switching_enable(switching_enable), .cur_src_en(cur_src_en),
    .fault_pin_out(fault_pin_out), .fault_pin_oe(fault_pin_oe), .ext_low(ext_low),
    .overload(overload), .base_mv(base_mv), .dv_mv(dv_mv), .ls_on(ls_on),
    .ls_over_limit(ls_over_limit), .fault_pin_in(fault_pin_in), .adc_mv(adc_mv));

  // clock, 50 ns period
  initial begin
    forever #25 mclk = ~mclk;
  end

  task automatic end_sim();
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic cmp_apb(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: apb got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
  endtask

  // cycles until fault_mode, switching_enable or cur_src_en reach lvl
  task automatic wait_for(input int which, input logic lvl, output int c);
    logic v;
    c = 0;
    do begin
      @(posedge mclk);
      c++;
      v = (which == 0) ? fault_mode : (which == 1) ? switching_enable : cur_src_en;
    end while (v !== lvl && c < 9999);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] ex);
    exp_q.push_back(ex);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // reset, limit pin measurement and soft-start for level k+1
  task automatic start(input int k);
    int l;
    l = (1000 * (k + 1) + 3) / 6;
    dv_mv <= DVS[k];
    base_mv <= 12'(1000 + ({$random(seed)} % 1000));
    reset <= 1'b1;
    regulator_ok <= 1'b0;
    tick(3);
    reset <= 1'b0;
    cmp({fast_limit_ma, programmed_current_limit, 5'h0, fault_pin_oe, switching_enable,
         cur_src_en}, {13'h1388, 11'h0, 8'h4});
    tick(5);
    regulator_ok <= 1'b1;
    wait_for(2, 1'b1, n);
    wait_for(2, 1'b0, n);
    cmp(32'(n >= 1995 && n <= 2005), 32'h1);
    wait_for(1, 1'b1, n);
    cmp(32'(fast_limit_ma), 32'h1388);
    tick(SS + 4);
    cmp({fast_limit_ma, programmed_current_limit, 7'h0, cur_src_en},
        {13'(5 * l), 11'(l), 8'h0});
    apb(1'b0, `BDFP_OFF_MEAS, 32'h0, {5'h0, base_mv, 4'h0, 12'(base_mv + dv_mv)});
  endtask

  // match each answer with the oldest noted expectation
  always @(posedge mclk) begin
    if (pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("Error at %0t: apb got %0h expected %0h", $time, {pslverr, prdata}, 33'h0);
      end else cmp_apb({pslverr, prdata}, exp_q.pop_front());
    end
  end

  // cut a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      end_sim();
    end
  end

  // main sequence
  initial begin
    for (int k = 0; k < 6; k++) start(k);
    start(2);
    apb(1'b0, `BDFP_OFF_CTRL, 32'h0, 33'h1);
    apb(1'b1, `BDFP_OFF_CTRL, 32'h0, 33'h0);
    tick(3);
    cmp(32'(switching_enable), 32'h0);
    apb(1'b1, `BDFP_OFF_CTRL, 32'h1, 33'h0);
    apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
    apb(1'b1, `BDFP_OFF_STATUS, $random(seed), 33'h0);
    apb(1'b0, `BDFP_OFF_SLOW, 32'h0, 33'h0);
    wait_for(1, 1'b1, n);
    ext_low <= 1'b1;
    tick(5);
    cmp(32'({switching_enable, fault_mode}), 32'h0);
    ext_low <= 1'b0;
    wait_for(1, 1'b1, n);
    tick(SS + 5);
    // fast trips: one cycle is rejected, two cycles trip
    for (int k = 0; k < 2; k++) begin
      {hs_over_fast, ls_over_fast} <= (k == 0) ? 2'b10 : 2'b01;
      tick(1);
      {hs_over_fast, ls_over_fast} <= 2'b00;
      tick(8);
      cmp(32'(fault_mode), 32'h0);
      {hs_over_fast, ls_over_fast} <= (k == 0) ? 2'b10 : 2'b01;
      tick(2);
      {hs_over_fast, ls_over_fast} <= 2'b00;
      wait_for(0, 1'b1, n);
      cmp(32'(n <= 4), 32'h1);
      cmp(32'({fault_pin_out, fault_pin_oe, switching_enable}), 32'h2);
      wait_for(0, 1'b0, n);
      cmp(32'(n >= RS - 4 && n <= RS + 4), 32'h1);
      cmp(32'(fast_limit_ma), 32'h1388);
      tick(SS + 4);
      cmp(32'(fast_limit_ma), 32'h9C4);
    end
    // slow trip: current out of the node, one over cycle, then sustained
    into_switch_node <= 1'b0;
    overload <= 1'b1;
    tick(300);
    cmp(32'(fault_mode), 32'h0);
    overload <= 1'b0;
    into_switch_node <= 1'b1;
    // start at a fresh low-side turn-on
    while (ls_on !== 1'b0) @(posedge mclk);
    while (ls_on !== 1'b1) @(posedge mclk);
    overload <= 1'b1;
    tick(5);
    overload <= 1'b0;
    tick(2500);
    apb(1'b0, `BDFP_OFF_SLOW, 32'h0, 33'h0);
    overload <= 1'b1;
    wait_for(0, 1'b1, n);
    cmp(32'(n >= UP && n <= UP + 68), 32'h1);
    wait_for(0, 1'b0, n);
    tick(SS - 5);
    cmp(32'(fault_mode), 32'h0);
    overload <= 1'b0;
    tick(200);
    ov_above_trip <= 1'b1;
    tick(20);
    ov_above_trip <= 1'b0;
    tick(8);
    cmp(32'(fault_mode), 32'h0);
    // overvoltage then thermal fault, each held by its release level
    for (int k = 0; k < 2; k++) begin
      {ov_below_release, thermal_cool} <= (k == 0) ? 2'b01 : 2'b10;
      {ov_above_trip, thermal_shutdown} <= (k == 0) ? 2'b10 : 2'b01;
      wait_for(0, 1'b1, n);
      cmp(32'((k == 0) ? (n >= 26 && n <= 32) : (n <= 5)), 32'h1);
      cmp(32'({fault_pin_oe, switching_enable}), 32'h2);
      {ov_above_trip, thermal_shutdown} <= 2'b00;
      tick(RS + 20);
      cmp(32'(fault_mode), 32'h1);
      {ov_below_release, thermal_cool} <= 2'b11;
      wait_for(0, 1'b0, n);
      cmp(32'(n <= 6), 32'h1);
      tick(SS + 5);
    end
    end_sim();
  end
endmodule
